/* src/misc_config_regs.sv */
// Purpose: Threshold, identification, global control, indirect counter access,
//          power-event control and interrupt registers
// Assumes: Host port and all status inputs except energy detect on clk_sys_i
// Notes:   Read data stands in the cycle after the read strobe only
`timescale 1ns/1ps
`default_nettype none
module misc_config_regs
  import misc_regs_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYCLES_DFLT, // Energy persistence time
  parameter logic [7:0]  FAMILY_CODE = 8'h5A,            // Arbitrary value
  parameter logic [3:0]  CHIP_CODE   = 4'h3,             // Arbitrary value
  parameter logic [2:0]  REV_CODE    = 3'h1              // Arbitrary value
) (
  input  wire logic               clk_sys_i,            // System clock
  input  wire logic               rst_n_i,              // Async reset, active low
  input  wire logic [ADDR_W-1:0]  reg_addr_i,           // Register byte address
  input  wire logic [DATA_W-1:0]  reg_wdata_i,          // Write data
  input  wire logic               reg_wr_i,             // Write strobe
  input  wire logic               reg_rd_i,             // Read strobe
  output logic      [DATA_W-1:0]  reg_rdata_o,          // Read data, next cycle
  input  wire logic [NUM_CNT-1:0] count_event_i,        // Counter increment pulses
  input  wire logic               ind_link_i,           // Link up
  input  wire logic               ind_act_i,            // Traffic activity
  input  wire logic               ind_speed_i,          // High speed mode
  output logic                    port_indicator_a_o,   // First port indicator
  output logic                    port_indicator_b_o,   // Second port indicator
  output logic [THRESH_W-1:0]     overrun_threshold_o,  // Overrun level, dwords
  input  wire logic [WSTAT_W-1:0] wake_event_i,         // Wake event pulses
  input  wire logic               clocks_ready_i,       // Clocks run, host served
  input  wire logic               low_power_i,          // In low-power state
  input  wire logic               energy_detect_i,      // Line energy, async pin
  output logic                    wake_up_o,            // Auto wake-up pulse
  output logic                    power_event_output_o, // Power-event pin level
  output logic                    irq_o                 // Interrupt, active high
);
  counter_if cif ();

  logic [DATA_W-1:0]  thresh;
  logic               id_spare;
  logic [DATA_W-1:0]  gctrl;
  logic [DATA_W-1:0]  icmd;
  logic [DATA_W-1:0]  data_lo;
  logic [DATA_W-1:0]  data_hi;
  logic [DATA_W-1:0]  pmectl;
  logic [WSTAT_W-1:0] wake_stat;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  logic               pme_active;
  logic               energy_meta;
  logic               energy_sync;
  logic [WAKE_CW-1:0] wake_cnt;
  logic [DATA_W-1:0]  next_rdata;

  logic               wr_thresh;
  logic               wr_id;
  logic               wr_gctrl;
  logic               wr_icmd;
  logic               wr_lo;
  logic               wr_hi;
  logic               wr_pmectl;
  logic               wr_istat;
  logic               wr_imask;
  logic               cmd_rd_en;
  logic               cmd_sel_ok;
  logic               cmd_read;
  logic               cmd_bad;
  logic               auto_wake;
  logic               delay_en;
  logic               pme_hold;
  logic               pme_now;
  logic               wake_arm;
  logic               wake_fire;
  logic [IRQ_W-1:0]   irq_event;
  logic [WSTAT_W-1:0] wake_clr;

  assign wr_thresh = reg_wr_i && (reg_addr_i == OFF_THRESH);
  assign wr_id     = reg_wr_i && (reg_addr_i == OFF_CHIP_ID);
  assign wr_gctrl  = reg_wr_i && (reg_addr_i == OFF_GCTRL);
  assign wr_icmd   = reg_wr_i && (reg_addr_i == OFF_ICMD);
  assign wr_lo     = reg_wr_i && (reg_addr_i == OFF_DATA_LO);
  assign wr_hi     = reg_wr_i && (reg_addr_i == OFF_DATA_HI);
  assign wr_pmectl = reg_wr_i && (reg_addr_i == OFF_PMECTL);
  assign wr_istat  = reg_wr_i && (reg_addr_i == OFF_IRQ_STAT);
  assign wr_imask  = reg_wr_i && (reg_addr_i == OFF_IRQ_MASK);

  // Command decode uses the fields of the word being written
  assign cmd_rd_en  = reg_wdata_i[RD_EN_BIT]; // R6
  assign cmd_sel_ok = (reg_wdata_i[TSEL_LO+1:TSEL_LO] == TSEL_COUNTERS); // R8
  assign cmd_read   = wr_icmd && cmd_rd_en && cmd_sel_ok; // R5 R6 R8
  assign cmd_bad    = wr_icmd && cmd_rd_en && !cmd_sel_ok; // R8

  assign cif.rd_req    = cmd_read; // R5
  assign cif.rd_addr   = reg_wdata_i[IADDR_W-1:0]; // R9
  assign cif.cnt_event = count_event_i;

  counter_bank u_counter_bank (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .cif       (cif)
  );

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thresh <= THRESH_RST; // R1
    end else if (wr_thresh) begin
      thresh <= reg_wdata_i;
    end
  end

  assign overrun_threshold_o = thresh[THRESH_W-1:0]; // R1

  // Only the spare bit of the identification word is writable
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      id_spare <= 1'b0;
    end else if (wr_id) begin
      id_spare <= reg_wdata_i[0]; // R2 R3
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gctrl <= GCTRL_RST; // R4
    end else if (wr_gctrl) begin
      gctrl <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_indicator_a_o <= 1'b0;
      port_indicator_b_o <= 1'b0;
    end else if (gctrl[IND_SEL_BIT]) begin // R4
      port_indicator_a_o <= ind_link_i;
      port_indicator_b_o <= ind_act_i;
    end else begin
      port_indicator_a_o <= ind_speed_i;
      port_indicator_b_o <= ind_link_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      icmd <= ICMD_RST;
    end else if (wr_icmd) begin
      icmd <= reg_wdata_i; // R5
    end
  end

  // Captured value replaces any earlier host write
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_lo <= DATA_RST;
      data_hi <= DATA_RST;
    end else if (cmd_read) begin
      data_lo <= cif.rd_data[DATA_W-1:0]; // R10
      data_hi <= cif.rd_data[CNT_W-1:DATA_W]; // R11
    end else begin
      if (wr_lo) begin
        data_lo <= reg_wdata_i;
      end
      if (wr_hi) begin
        data_hi <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pmectl <= PMECTL_RST;
    end else if (wr_pmectl) begin
      pmectl <= reg_wdata_i & PMECTL_RW_MASK;
    end
  end

  // Wake status: a new event wins over a write-one clear
  assign wake_clr = wr_pmectl ? reg_wdata_i[WSTAT_LO+WSTAT_W-1:WSTAT_LO] : '0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_stat <= '0;
    end else begin
      wake_stat <= (wake_stat & ~wake_clr) | wake_event_i;
    end
  end

  assign auto_wake = pmectl[AUTO_WAKE_BIT];
  assign delay_en  = pmectl[PME_DELAY_BIT];
  assign pme_hold  = auto_wake && delay_en && !clocks_ready_i; // R12 R13
  assign pme_now   = (|wake_stat) && !pme_hold; // R12

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pme_active <= 1'b0;
    end else begin
      pme_active <= pme_now; // R12 R13
    end
  end

  // Pin idles high because the polarity bit resets to active low
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_event_output_o <= 1'b1;
    end else begin
      power_event_output_o <= pmectl[PME_POL_BIT] ? pme_now : !pme_now;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      energy_meta <= 1'b0;
      energy_sync <= 1'b0;
    end else begin
      energy_meta <= energy_detect_i;
      energy_sync <= energy_meta;
    end
  end

  // Counts consecutive energy cycles and parks at the limit
  assign wake_arm  = auto_wake && low_power_i && energy_sync; // R14
  assign wake_fire = wake_arm && (wake_cnt == WAKE_CW'(WAKE_CYCLES - 1)); // R14

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_cnt <= '0;
    end else if (!wake_arm) begin
      wake_cnt <= '0;
    end else if (wake_cnt != WAKE_CW'(WAKE_CYCLES)) begin
      wake_cnt <= wake_cnt + WAKE_CW'(1); // R14
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_up_o <= 1'b0;
    end else begin
      wake_up_o <= wake_fire;
    end
  end

  always_comb begin
    irq_event              = '0;
    irq_event[IRQ_RD_DONE] = cmd_read;
    irq_event[IRQ_BAD_SEL] = cmd_bad;
    irq_event[IRQ_PME]     = pme_now && !pme_active;
    irq_event[IRQ_WAKE]    = wake_fire;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat <= '0;
    end else if (wr_istat) begin
      irq_stat <= (irq_stat & ~reg_wdata_i[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask <= '0;
    end else if (wr_imask) begin
      irq_mask <= reg_wdata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  always_comb begin
    next_rdata = '0;
    case (reg_addr_i)
      OFF_THRESH:   next_rdata = thresh;
      OFF_CHIP_ID:  next_rdata = {FAMILY_CODE, CHIP_CODE, REV_CODE, id_spare}; // R2 R3
      OFF_GCTRL:    next_rdata = gctrl;
      OFF_ICMD:     next_rdata = icmd;
      OFF_DATA_LO:  next_rdata = data_lo; // R10
      OFF_DATA_HI:  next_rdata = data_hi; // R11
      OFF_PMECTL:   next_rdata = pmectl | (DATA_W'(wake_stat) << WSTAT_LO);
      OFF_IRQ_STAT: next_rdata = DATA_W'(irq_stat);
      OFF_IRQ_MASK: next_rdata = DATA_W'(irq_mask);
      default:      next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_thresh_write: assert property ( // R1
    wr_thresh |=> (overrun_threshold_o == $past(reg_wdata_i[THRESH_W-1:0])))
    else $error("threshold did not follow write");

  chk_id_fixed: assert property ( // R2
    (reg_rd_i && (reg_addr_i == OFF_CHIP_ID))
      |=> (reg_rdata_o[DATA_W-1:CHIP_LO] == {FAMILY_CODE, CHIP_CODE}))
    else $error("identification codes wrong on read");

  chk_rev_fixed: assert property ( // R3
    (reg_rd_i && (reg_addr_i == OFF_CHIP_ID)) |=> (reg_rdata_o[CHIP_LO-1:REV_LO] == REV_CODE))
    else $error("revision field wrong on read");

  chk_indicator_mode: assert property ( // R4
    gctrl[IND_SEL_BIT] |=> ((port_indicator_a_o == $past(ind_link_i)) &&
                            (port_indicator_b_o == $past(ind_act_i))))
    else $error("indicators not showing link and activity");

  chk_read_capture: assert property ( // R10
    cmd_read |=> ((data_lo == $past(cif.rd_data[DATA_W-1:0])) &&
                  (data_hi == $past(cif.rd_data[CNT_W-1:DATA_W]))))
    else $error("indirect read value not captured");

  chk_read_visible: assert property ( // R11
    (reg_rd_i && (reg_addr_i == OFF_DATA_HI))
      |=> (reg_rdata_o == $past(data_hi)))
    else $error("data high read does not show captured value");

  chk_noop_cmd: assert property ( // R6
    (wr_icmd && !reg_wdata_i[RD_EN_BIT]) |=> ($stable(data_lo) && $stable(data_hi)))
    else $error("command without read enable changed data");

  chk_bad_select: assert property ( // R8
    (wr_icmd && reg_wdata_i[RD_EN_BIT] && !cmd_sel_ok)
      |=> (irq_stat[IRQ_BAD_SEL] && $stable(data_lo) && $stable(data_hi)))
    else $error("reserved table select reached the counters");

  chk_cmd_launch: assert property ( // R5
    cmd_read |=> irq_stat[IRQ_RD_DONE])
    else $error("indirect read not flagged");

  chk_pme_held: assert property ( // R12 R13
    pme_hold |=> !pme_active)
    else $error("power event asserted before clocks ready");

  chk_pme_direct: assert property ( // R13
    ((|wake_stat) && !(auto_wake && delay_en)) |=> pme_active)
    else $error("power event delayed without delay enabled");

  chk_wake_cause: assert property ( // R14
    wake_up_o |-> $past(auto_wake && low_power_i && energy_sync))
    else $error("wake-up without armed energy persistence");

  chk_irq_level: assert property (
    (|(irq_stat & irq_mask)) |=> irq_o)
    else $error("interrupt not raised for unmasked status");
endmodule
`default_nettype wire

/* include/misc_regs_pkg.sv */
// Purpose: Constants for the misc configuration and counter access register bank
// Assumes: 8-bit byte address, 16-bit register data, one 125 MHz clock
// Notes:   Offsets are byte addresses of 16-bit registers
//
// Overview of operation
// R1: Overrun threshold is a 12-bit double-word count, reset 0x0040 (256 bytes).
// R2: Identification returns read-only family code bits 15-8, chip code bits 7-4.
// R3: Identification bits 3-1 report the silicon revision, read-only.
// R4: Global control bit 9 set makes indicators show activity and link; resets zero.
// R5: Every write to the indirect command register launches one command.
// R6: Read-enable bit set performs an indirect read; clear means no operation.
// R7: An indirect read clears the counter after capturing its value.
// R8: Table select 11 targets the counters; other codes are reserved.
// R9: A 5-bit address picks one of 32 counters.
// R10: Data low register shows bits 15-0 of the last indirect value.
// R11: Data high register shows bits 31-16 of the last indirect value.
// R12: Delay bit set holds power-event output until clocks run and host is served.
// R13: Delay bit only matters while the automatic wake-up enable bit is set.
// R14: Auto wake-up wakes the device once energy persists past the wake-up time.
// R15: Host writes one read command, then reads data low, then data high.
// R16: Host writes reserved global control fields back with their reset values.
package misc_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CNT = 32;
  localparam int CNT_W = 32;
  localparam int IADDR_W = 5;
  localparam int THRESH_W = 12;
  localparam int WSTAT_W = 4;
  localparam int IRQ_W = 4;
  localparam int WAKE_CW = 24;

  localparam logic [ADDR_W-1:0] OFF_THRESH = 8'hB4;
  localparam logic [ADDR_W-1:0] OFF_CHIP_ID = 8'hC0;
  localparam logic [ADDR_W-1:0] OFF_GCTRL = 8'hC6;
  localparam logic [ADDR_W-1:0] OFF_ICMD = 8'hC8;
  localparam logic [ADDR_W-1:0] OFF_DATA_LO = 8'hD0;
  localparam logic [ADDR_W-1:0] OFF_DATA_HI = 8'hD2;
  localparam logic [ADDR_W-1:0] OFF_PMECTL = 8'hD4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'hE0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'hE2;

  localparam logic [DATA_W-1:0] THRESH_RST = 16'h0040;
  localparam logic [DATA_W-1:0] GCTRL_RST = 16'h0835;
  localparam logic [DATA_W-1:0] ICMD_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [DATA_W-1:0] PMECTL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] PMECTL_RW_MASK = 16'h7FC3;

  localparam int IND_SEL_BIT = 9;
  localparam int RD_EN_BIT = 12;
  localparam int TSEL_LO = 10;
  localparam logic [1:0] TSEL_COUNTERS = 2'h3;
  localparam int FAMILY_LO = 8;
  localparam int CHIP_LO = 4;
  localparam int REV_LO = 1;
  localparam int PME_DELAY_BIT = 14;
  localparam int PME_POL_BIT = 12;
  localparam int AUTO_WAKE_BIT = 7;
  localparam int WSTAT_LO = 2;

  localparam int IRQ_RD_DONE = 0;
  localparam int IRQ_BAD_SEL = 1;
  localparam int IRQ_PME = 2;
  localparam int IRQ_WAKE = 3;

  localparam int unsigned WAKE_TIME_MS = 128;
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned WAKE_CYCLES_DFLT = WAKE_TIME_MS * CLK_KHZ;
endpackage

/* include/counter_if.sv */
// Purpose: Carrier between the register bank and the statistics counter array
// Assumes: Single clock domain, read data valid in the request cycle
// Notes:   Request is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface counter_if;
  import misc_regs_pkg::*;
  logic               rd_req;    // Capture and clear one counter
  logic [IADDR_W-1:0] rd_addr;   // Counter index
  logic [CNT_W-1:0]   rd_data;   // Current value of the indexed counter
  logic [NUM_CNT-1:0] cnt_event; // One-cycle increment pulses

  modport ctrl (output rd_req, output rd_addr, output cnt_event, input rd_data);
  modport bank (input rd_req, input rd_addr, input cnt_event, output rd_data);
endinterface
`default_nettype wire

/* src/counter_bank.sv */
// Purpose: Array of 32 statistics counters with capture-and-clear read
// Assumes: Event pulses come from logic on the same clock
// Notes:   An event in the clearing cycle is kept as a count of one
`timescale 1ns/1ps
`default_nettype none
module counter_bank
  import misc_regs_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i,   // Asynchronous reset, active low
  counter_if.bank  cif        // Counter access port
);
  logic [CNT_W-1:0] cnt_q [NUM_CNT];

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cnt_q[g] <= '0;
        end else if (cif.rd_req && (cif.rd_addr == IADDR_W'(g))) begin // R7 R9
          cnt_q[g] <= CNT_W'(cif.cnt_event[g]);
        end else if (cif.cnt_event[g]) begin
          cnt_q[g] <= cnt_q[g] + CNT_W'(1);
        end
      end
    end
  endgenerate

  assign cif.rd_data = cnt_q[cif.rd_addr]; // R9

  chk_clear_on_read: assert property ( // R7
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cif.rd_req |=> (cnt_q[$past(cif.rd_addr)] <= CNT_W'(1)))
    else $error("counter not cleared after indirect read");

  chk_other_kept: assert property ( // R9
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (cif.rd_req && (cif.rd_addr != 5'h00) && !cif.cnt_event[0])
      |=> $stable(cnt_q[0]))
    else $error("unaddressed counter changed on indirect read");
endmodule
`default_nettype wire

/* verification/host_model.sv */
// Purpose: Host processor model on the register port
// Assumes: Strobes change just after the rising edge, one cycle long
// Notes:   Read data is taken in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module host_model
  import misc_regs_pkg::*;
(
  input  wire logic              clk_i,   // System clock
  input  wire logic [DATA_W-1:0] rdata_i, // Read data
  output logic      [ADDR_W-1:0] addr_o,  // Byte address
  output logic      [DATA_W-1:0] wdata_o, // Write data
  output logic                   wr_o,    // Write strobe
  output logic                   rd_o     // Read strobe
);
  initial begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* verification/misc_config_and_counter_access_regs_test.sv */
// Purpose: Self-checking bench for the misc configuration register bank
// Assumes: Wake persistence shortened to 8 cycles
// Notes:   Host traffic goes through the host model tasks
`timescale 1ns/1ps
`default_nettype none
module misc_config_and_counter_access_regs_test;
  import misc_regs_pkg::*;
  localparam logic [7:0] FAM = 8'hA6; // Arbitrary value
  localparam logic [3:0] CHP = 4'h9;  // Arbitrary value
  localparam logic [2:0] REV = 3'h5;  // Arbitrary value
  logic clk, rst_n, link, act, speed, clk_rdy, low_pwr, energy;
  logic wr, rd, ind_a, ind_b, wake, power_event_output, irq;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wdata, rdata;
  logic [NUM_CNT-1:0] cnt_ev;
  logic [WSTAT_W-1:0] wake_ev;
  logic [THRESH_W-1:0] thr;
  int n_fail = 0;
  int comparisons = 0;

  always #4 clk = ~clk;

  host_model host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
                   .wr_o(wr), .rd_o(rd));
  misc_config_regs #(.WAKE_CYCLES(8), .FAMILY_CODE(FAM), .CHIP_CODE(CHP), .REV_CODE(REV)) dut (
    .clk_sys_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .count_event_i(cnt_ev),
    .ind_link_i(link), .ind_act_i(act), .ind_speed_i(speed),
    .port_indicator_a_o(ind_a), .port_indicator_b_o(ind_b), .overrun_threshold_o(thr),
    .wake_event_i(wake_ev), .clocks_ready_i(clk_rdy), .low_power_i(low_pwr),
    .energy_detect_i(energy), .wake_up_o(wake), .power_event_output_o(power_event_output), .irq_o(irq));

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    chk(nm, exp, d);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clk);
      cnt_ev <= 32'h1 << idx;
      @(posedge clk);
      cnt_ev <= '0;
    end
  endtask

  // Read one counter: command, then low word, then high word
  task automatic cnt_rd(input logic [4:0] idx, input logic [15:0] lo);
    host.wr(OFF_ICMD, 16'h1C00 | 16'(idx));
    rchk("data low", OFF_DATA_LO, lo);
    rchk("data high", OFF_DATA_HI, 16'h0000);
  endtask

  task automatic t_reset();
    chk("threshold out", 16'h0040, 16'(thr));
    rchk("threshold", OFF_THRESH, 16'h0040);
    rchk("chip id", OFF_CHIP_ID, {FAM, CHP, REV, 1'b0});
    rchk("global ctrl", OFF_GCTRL, 16'h0835);
    rchk("data low", OFF_DATA_LO, 16'h0000);
    rchk("data high", OFF_DATA_HI, 16'h0000);
    rchk("unmapped", 8'h10, 16'h0000);
  endtask

  task automatic t_id_thresh();
    host.wr(OFF_CHIP_ID, 16'hFFFF);
    rchk("chip id wr", OFF_CHIP_ID, {FAM, CHP, REV, 1'b1});
    host.wr(OFF_THRESH, 16'h0FFF);
    settle(1);
    chk("threshold out", 16'h0FFF, 16'(thr));
    host.wr(8'h10, 16'h1234);
    rchk("unmapped", 8'h10, 16'h0000);
  endtask

  task automatic ind(input logic l, input logic a, input logic s, input logic [1:0] e);
    @(posedge clk);
    link  <= l;
    act   <= a;
    speed <= s;
    settle(3);
    chk("indicators", 16'(e), 16'({ind_a, ind_b}));
  endtask

  task automatic t_indic();
    host.wr(OFF_GCTRL, GCTRL_RST | 16'h0200);
    ind(1'b1, 1'b0, 1'b0, 2'b10);
    ind(1'b0, 1'b1, 1'b0, 2'b01);
    host.wr(OFF_GCTRL, GCTRL_RST);
    ind(1'b0, 1'b1, 1'b1, 2'b10);
    ind(1'b1, 1'b0, 1'b0, 2'b01);
  endtask

  task automatic t_counter();
    host.wr(OFF_IRQ_MASK, 16'h0001);
    pulse(5, 3);
    pulse(31, 1);
    host.wr(OFF_DATA_HI, 16'hBEEF);
    cnt_rd(5'd5, 16'h0003);
    settle(2);
    chk("irq", 16'h0001, 16'(irq));
    rchk("irq status", OFF_IRQ_STAT, 16'h0001);
    host.wr(OFF_IRQ_STAT, 16'h000F);
    settle(2);
    chk("irq clear", 16'h0000, 16'(irq));
    cnt_rd(5'd5, 16'h0000);
    cnt_rd(5'd31, 16'h0001);
    pulse(31, 2);
    host.wr(OFF_ICMD, 16'h0C1F);
    rchk("no-op", OFF_DATA_LO, 16'h0001);
    host.wr(OFF_IRQ_STAT, 16'h000F);
    for (int t = 0; t < 3; t++) begin
      host.wr(OFF_ICMD, 16'h101F | 16'(t << 10));
      rchk("bad select", OFF_DATA_LO, 16'h0001);
    end
    rchk("irq status", OFF_IRQ_STAT, 16'h0002);
    chk("irq masked", 16'h0000, 16'(irq));
    cnt_rd(5'd31, 16'h0002);
  endtask

  task automatic evt();
    @(posedge clk);
    wake_ev <= 4'h1;
    @(posedge clk);
    wake_ev <= 4'h0;
  endtask

  task automatic t_power();
    host.wr(OFF_PMECTL, 16'h5080);
    settle(2);
    chk("pme idle", 16'h0000, 16'(power_event_output));
    evt();
    settle(4);
    chk("pme held", 16'h0000, 16'(power_event_output));
    @(posedge clk);
    clk_rdy <= 1'b1;
    settle(3);
    chk("pme late", 16'h0001, 16'(power_event_output));
    host.wr(OFF_PMECTL, 16'h50BC);
    @(posedge clk);
    clk_rdy <= 1'b0;
    settle(2);
    chk("pme clear", 16'h0000, 16'(power_event_output));
    host.wr(OFF_PMECTL, 16'h5000);
    evt();
    settle(3);
    chk("pme no gate", 16'h0001, 16'(power_event_output));
    host.wr(OFF_PMECTL, 16'h503C);
  endtask

  task automatic wake_cnt(output int seen);
    seen = 0;
    @(posedge clk);
    energy <= 1'b1;
    repeat (24) begin
      settle(1);
      if (wake === 1'b1) seen++;
    end
    @(posedge clk);
    energy <= 1'b0;
  endtask

  task automatic t_wake();
    int seen;
    @(posedge clk);
    low_pwr <= 1'b1;
    host.wr(OFF_PMECTL, 16'h0000);
    wake_cnt(seen);
    chk("wake off", 16'h0000, 16'(seen));
    host.wr(OFF_PMECTL, 16'h0080);
    wake_cnt(seen);
    chk("wake on", 16'h0001, 16'(seen));
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {link, act, speed, clk_rdy, low_pwr, energy} = '0;
    cnt_ev = '0;
    wake_ev = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    t_reset();
    t_id_thresh();
    t_indic();
    t_counter();
    t_power();
    t_wake();
    test_done();
  end

  initial begin
    #50000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
